/* rtl/dpd_pkg.sv */
// Package: register map, field layout, reset values and types for display PLL divisor control
package dpd_pkg;

    // ********************************
    // Register offsets (byte addresses)
    // ********************************
    localparam logic [15:0] DPD_SET0_DIV_OFS = 16'h6000;
    localparam logic [15:0] DPD_SET1_DIV_OFS = 16'h6004;
    localparam logic [15:0] DPD_SET2_DIV_OFS = 16'h6008;
    localparam logic [15:0] DPD_PANEL_DIV_OFS = 16'h600c;
    localparam logic [15:0] DPD_POST_SEL_OFS = 16'h6010;
    localparam logic [15:0] DPD_SRC_SEL_OFS = 16'h6014;
    localparam logic [15:0] DPD_PANEL_CTL_OFS = 16'h6018;

    // ********************************
    // Field positions
    // ********************************
    localparam int DPD_N_LSB = 16;
    localparam int DPD_N_MSB = 25;
    localparam int DPD_M_LSB = 0;
    localparam int DPD_M_MSB = 9;
    localparam int DPD_POST_LSB = 4;
    localparam int DPD_POST_MSB = 6;
    localparam int DPD_LOOP_BIT = 2;
    localparam int DPD_SRC_LSB = 2;
    localparam int DPD_SRC_MSB = 3;
    localparam int DPD_PANEL_EN_HI = 31;
    localparam int DPD_PANEL_EN_LO = 0;
    localparam int DPD_PANEL_BYTE = 3;
    localparam int DPD_NUM_SETS = 4;

    // ********************************
    // Masks and reset values
    // ********************************
    localparam logic [31:0] DPD_DIV_MASK = 32'h03ff03ff;
    localparam logic [7:0] DPD_POST_BYTE_MASK = 8'h74;
    localparam logic [31:0] DPD_SET0_DIV_RST = 32'h00030013;
    localparam logic [31:0] DPD_SET1_DIV_RST = 32'h00100053;
    localparam logic [31:0] DPD_SET2_DIV_RST = 32'h00030013;
    localparam logic [31:0] DPD_PANEL_DIV_RST = 32'h00030013;
    localparam logic [31:0] DPD_POST_SEL_RST = 32'h40404040;
    localparam logic [1:0] DPD_SRC_SEL_RST = 2'h0;

    // Active set index
    typedef enum logic [1:0] {
        DPD_SET_ZERO,
        DPD_SET_ONE,
        DPD_SET_TWO,
        DPD_SET_PANEL
    } dpd_set_e;

    // One VCO register file entry
    typedef struct packed {
        logic [9:0] n_div;
        logic [9:0] m_div;
        logic [2:0] post_div;
        logic loop_div16;
    } dpd_vco_s;

    // Register-bus write/read request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [31:0] wdata;
        logic [3:0] be;
    } dpd_req_s;

endpackage

/* rtl/dpd_vco_file.sv */
// VCO register file: one registered entry per clock set with a registered read port
`timescale 1ns/10ps
module dpd_vco_file
    import dpd_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Load port, one enable per set
    input wire logic [DPD_NUM_SETS-1:0] load,
    input dpd_vco_s load_data [DPD_NUM_SETS],
    // Read port
    input wire logic [1:0] rd_sel,
    output dpd_vco_s rd_data
);

    dpd_vco_s entry_reg [DPD_NUM_SETS];
    dpd_vco_s entry_next [DPD_NUM_SETS];
    dpd_vco_s rd_reg;
    dpd_vco_s rd_next;
    dpd_vco_s rst_val [DPD_NUM_SETS];
    logic [31:0] div_rst_val [DPD_NUM_SETS];

    // Reset image mirrors the staging registers' reset contents
    assign div_rst_val[0] = DPD_SET0_DIV_RST;
    assign div_rst_val[1] = DPD_SET1_DIV_RST;
    assign div_rst_val[2] = DPD_SET2_DIV_RST;
    assign div_rst_val[3] = DPD_PANEL_DIV_RST;
    for (genvar g = 0; g < DPD_NUM_SETS; g++) begin : g_rst_val
        assign rst_val[g] = '{
            n_div: div_rst_val[g][DPD_N_MSB:DPD_N_LSB],
            m_div: div_rst_val[g][DPD_M_MSB:DPD_M_LSB],
            post_div: DPD_POST_SEL_RST[8*g+DPD_POST_LSB +: 3],
            loop_div16: DPD_POST_SEL_RST[8*g+DPD_LOOP_BIT]
        };
    end

    // Next entries: whole entry is replaced at once so the PLL never sees half an update
    always_comb begin
        for (int i = 0; i < DPD_NUM_SETS; i++) begin
            entry_next[i] = load[i] ? load_data[i] : entry_reg[i];
        end
        rd_next = entry_next[rd_sel];
    end

    // Register the entries and the read data
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < DPD_NUM_SETS; i++) begin
                entry_reg[i] <= rst_val[i];
            end
            rd_reg <= rst_val[0];
        end else begin
            for (int i = 0; i < DPD_NUM_SETS; i++) begin
                entry_reg[i] <= entry_next[i];
            end
            rd_reg <= rd_next;
        end
    end

    assign rd_data = rd_reg;

endmodule

/* rtl/dpd_ctrl.sv */
// Display PLL divisor control: staging registers, trigger writes and active-set selection
`timescale 1ns/10ps

module dpd_ctrl
    import dpd_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Register access
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [15:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic [3:0] REG_BE,
    output logic [31:0] REG_RDATA,
    output logic REG_RVALID,
    // Clock synthesizer side
    output logic [9:0] PLL_N_DIV,
    output logic [9:0] PLL_M_DIV,
    output logic [2:0] PLL_POST_DIV,
    output logic PLL_LOOP_DIV16,
    output logic [1:0] PLL_ACTIVE_SET
);

    // ********************************
    // Staging registers
    // ********************************
    logic [31:0] div_reg [DPD_NUM_SETS];
    logic [31:0] div_next [DPD_NUM_SETS];
    logic [31:0] post_reg;
    logic [31:0] post_next;
    logic [1:0] src_reg;
    logic [1:0] src_next;
    logic [31:0] panel_ctl_reg;
    logic [31:0] panel_ctl_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic rvalid_reg;
    logic rvalid_next;
    logic [1:0] active_reg;
    logic [1:0] active_next;

    logic [DPD_NUM_SETS-1:0] vco_load;
    dpd_vco_s vco_data [DPD_NUM_SETS];
    dpd_vco_s vco_rd;
    logic [31:0] div_rst [DPD_NUM_SETS];
    logic src_wr;
    logic panel_sel;
    logic [DPD_NUM_SETS-1:0] div_wr;
    logic post_wr;
    logic panel_wr;

    // ********************************
    // Reset images and address decode
    // ********************************
    // Staging reset values, one per set, in set order
    assign div_rst[0] = DPD_SET0_DIV_RST;
    assign div_rst[1] = DPD_SET1_DIV_RST;
    assign div_rst[2] = DPD_SET2_DIV_RST;
    assign div_rst[3] = DPD_PANEL_DIV_RST;

    // Source select field lives in byte 0 of its register
    assign src_wr = REG_WR && (REG_ADDR == DPD_SRC_SEL_OFS) && REG_BE[0];
    // One decode per register keeps staging and trigger logic in step
    assign post_wr = REG_WR && (REG_ADDR == DPD_POST_SEL_OFS);
    assign panel_wr = REG_WR && (REG_ADDR == DPD_PANEL_CTL_OFS);

    // Divisor registers are one word apart, panel divisor last
    for (genvar g = 0; g < DPD_NUM_SETS; g++) begin : g_div_hit
        assign div_wr[g] = REG_WR && (REG_ADDR == DPD_SET0_DIV_OFS + 16'(4 * g));
    end

    // ********************************
    // Register writes
    // ********************************
    // Divisor writes only touch staging; reserved bits are never stored
    always_comb begin
        for (int i = 0; i < DPD_NUM_SETS; i++) begin
            div_next[i] = div_reg[i];
            if (div_wr[i]) begin
                for (int b = 0; b < 4; b++) begin
                    if (REG_BE[b]) begin
                        div_next[i][8*b +: 8] = REG_WDATA[8*b +: 8] & DPD_DIV_MASK[8*b +: 8];
                    end
                end
            end
        end
        post_next = post_reg;
        if (post_wr) begin
            for (int b = 0; b < 4; b++) begin
                if (REG_BE[b]) begin
                    post_next[8*b +: 8] = REG_WDATA[8*b +: 8] & DPD_POST_BYTE_MASK;
                end
            end
        end
        src_next = src_wr ? REG_WDATA[DPD_SRC_MSB:DPD_SRC_LSB] : src_reg;
        panel_ctl_next = panel_ctl_reg;
        if (panel_wr) begin
            for (int b = 0; b < 4; b++) begin
                if (REG_BE[b]) begin
                    panel_ctl_next[8*b +: 8] = REG_WDATA[8*b +: 8];
                end
            end
        end
    end

    // ********************************
    // Transfers into the VCO register file
    // ********************************
    // Loading from the next values makes divisor and post byte land in the same cycle
    for (genvar g = 0; g < DPD_NUM_SETS; g++) begin : g_vco_load
        // Post byte write of set g, or a source-select write with byte 0 enabled, loads set g
        assign vco_load[g] = (post_wr && REG_BE[g]) || src_wr;
        // Entry is built in one piece so the synthesizer never sees a mix of two sets
        assign vco_data[g] = '{
            n_div: div_next[g][DPD_N_MSB:DPD_N_LSB],
            m_div: div_next[g][DPD_M_MSB:DPD_M_LSB],
            post_div: post_next[8*g+DPD_POST_LSB +: 3],
            loop_div16: post_next[8*g+DPD_LOOP_BIT]
        };
    end

    dpd_vco_file u_vco_file (
        .clk(CLK),
        .rst(RST),
        .load(vco_load),
        .load_data(vco_data),
        .rd_sel(active_next),
        .rd_data(vco_rd)
    );

    // ********************************
    // Active set selection
    // ********************************
    // Panel override wins; otherwise bit 3 means set two regardless of bit 2
    always_comb begin
        panel_sel = panel_ctl_next[DPD_PANEL_EN_HI] && panel_ctl_next[DPD_PANEL_EN_LO];
        if (panel_sel) begin
            active_next = DPD_SET_PANEL;
        end else begin
            case (src_next)
                2'h0: active_next = DPD_SET_ZERO;
                2'h1: active_next = DPD_SET_ONE;
                2'h2, 2'h3: active_next = DPD_SET_TWO;
                default: active_next = DPD_SET_ZERO;
            endcase
        end
    end

    // ********************************
    // Register reads
    // ********************************
    // Reads show staged values, not what the PLL is running on
    // A read in the same cycle as a write returns the value from before the write
    always_comb begin
        rdata_next = 32'h0;
        rvalid_next = REG_RD;
        if (REG_RD) begin
            case (REG_ADDR)
                DPD_SET0_DIV_OFS: rdata_next = div_reg[0];
                DPD_SET1_DIV_OFS: rdata_next = div_reg[1];
                DPD_SET2_DIV_OFS: rdata_next = div_reg[2];
                DPD_PANEL_DIV_OFS: rdata_next = div_reg[3];
                DPD_POST_SEL_OFS: rdata_next = post_reg;
                DPD_SRC_SEL_OFS: rdata_next = {28'h0, src_reg, 2'h0};
                DPD_PANEL_CTL_OFS: rdata_next = panel_ctl_reg;
                default: rdata_next = 32'h0;
            endcase
        end
    end

    // ********************************
    // State registers
    // ********************************
    // Register all state
    always_ff @(posedge CLK) begin
        if (RST) begin
            for (int i = 0; i < DPD_NUM_SETS; i++) begin
                div_reg[i] <= div_rst[i];
            end
            post_reg <= DPD_POST_SEL_RST;
            src_reg <= DPD_SRC_SEL_RST;
            panel_ctl_reg <= 32'h0;
            rdata_reg <= 32'h0;
            rvalid_reg <= 1'b0;
            active_reg <= DPD_SET_ZERO;
        end else begin
            for (int i = 0; i < DPD_NUM_SETS; i++) begin
                div_reg[i] <= div_next[i];
            end
            post_reg <= post_next;
            src_reg <= src_next;
            panel_ctl_reg <= panel_ctl_next;
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
            active_reg <= active_next;
        end
    end

    // ********************************
    // Outputs
    // ********************************
    // Outputs straight from flip-flops
    assign REG_RDATA = rdata_reg;
    assign REG_RVALID = rvalid_reg;
    assign PLL_N_DIV = vco_rd.n_div;
    assign PLL_M_DIV = vco_rd.m_div;
    assign PLL_POST_DIV = vco_rd.post_div;
    assign PLL_LOOP_DIV16 = vco_rd.loop_div16;
    assign PLL_ACTIVE_SET = active_reg;

endmodule

/* tb/dpd_ctrl_monitor.sv */
// Checker of the divisor control block ports
`timescale 1ns/10ps
module dpd_ctrl_monitor
    import dpd_pkg::*;
(
    // Clock, reset and register access
    input wire logic CLK,
    input wire logic RST,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [15:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic [3:0] REG_BE,
    input wire logic [31:0] REG_RDATA,
    input wire logic REG_RVALID,
    // Synthesizer side
    input wire logic [9:0] PLL_N_DIV,
    input wire logic [9:0] PLL_M_DIV,
    input wire logic [2:0] PLL_POST_DIV,
    input wire logic PLL_LOOP_DIV16,
    input wire logic [1:0] PLL_ACTIVE_SET
);
    // ******
    // Helpers
    // ******
    logic ovr_reg;
    logic ovr_next;
    wire logic sel_wr = REG_WR && (REG_ADDR == DPD_SRC_SEL_OFS || REG_ADDR == DPD_PANEL_CTL_OFS);
    wire logic trig = sel_wr || (REG_WR && REG_ADDR == DPD_POST_SEL_OFS);
    wire logic src_wr = REG_WR && REG_ADDR == DPD_SRC_SEL_OFS && REG_BE[0];
    wire logic [1:0] src_code = REG_WDATA[3] ? 2'h2 : {1'b0, REG_WDATA[2]};
    wire logic [7:0] act_byte = REG_WDATA[8*PLL_ACTIVE_SET +: 8];
    wire logic [2:0] act_post = act_byte[6:4];
    wire logic act_loop = act_byte[2];
    // Panel override, tracked from full-word writes only since partial ones are never issued
    always_comb begin
        ovr_next = ovr_reg;
        if (RST) begin
            ovr_next = 1'b0;
        end else if (REG_WR && REG_ADDR == DPD_PANEL_CTL_OFS && REG_BE == 4'hf) begin
            ovr_next = REG_WDATA[31] && REG_WDATA[0];
        end
    end
    // Override register
    always_ff @(posedge CLK) begin
        ovr_reg <= ovr_next;
    end
    // ******
    // Properties
    // ******
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    rd_answer_a: assert property (REG_RD |=> REG_RVALID)
        else $error("read not answered next cycle");
    rd_quiet_a: assert property (!REG_RD |=> !REG_RVALID && REG_RDATA == 32'h0)
        else $error("read data without a read");
    rsvd_zero_a: assert property (REG_RD && REG_ADDR <= DPD_PANEL_DIV_OFS
        |=> (REG_RDATA & ~DPD_DIV_MASK) == 32'h0)
        else $error("reserved divisor bits not zero");
    stage_hold_a: assert property (!$stable({PLL_N_DIV, PLL_M_DIV, PLL_POST_DIV, PLL_LOOP_DIV16})
        |-> $past(trig))
        else $error("divisors changed without a trigger");
    one_set_a: assert property (!$stable(PLL_ACTIVE_SET) |-> $past(sel_wr))
        else $error("active set changed without a select write");
    src_pick_a: assert property (src_wr && !ovr_reg |=> PLL_ACTIVE_SET == $past(src_code))
        else $error("wrong set for source select");
    panel_hold_a: assert property (ovr_reg |-> PLL_ACTIVE_SET == 2'h3)
        else $error("panel set not active under override");
    post_load_a: assert property (REG_WR && REG_ADDR == DPD_POST_SEL_OFS && REG_BE[PLL_ACTIVE_SET]
        |=> PLL_POST_DIV == $past(act_post) && PLL_LOOP_DIV16 == $past(act_loop))
        else $error("post divisor not loaded");
    rst_val_a: assert property ($fell(RST)
        |-> PLL_ACTIVE_SET == 2'h0 && PLL_N_DIV == 10'h3 && PLL_M_DIV == 10'h13)
        else $error("wrong outputs after reset");
    src_cov: cover property (src_wr && REG_WDATA[3]);
    panel_cov: cover property (ovr_reg && src_wr);
    post_cov: cover property (REG_WR && REG_ADDR == DPD_POST_SEL_OFS);
endmodule
bind dpd_ctrl dpd_ctrl_monitor dpd_ctrl_monitor_i(.*);

/* tb/dpd_synth_model.sv */
// Behavioural display clock synthesizer fed by the divisor outputs
`timescale 1ns/10ps
module dpd_synth_model
    import dpd_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Loop parameters
    input dpd_vco_s cfg,
    // Health
    output logic bad_cfg
);
    // A reserved post code would stall a real VCO, so it is latched as a fault
    always_ff @(posedge clk) begin
        if (rst) begin
            bad_cfg <= 1'b0;
        end else if (cfg.post_div > 3'h5) begin
            bad_cfg <= 1'b1;
        end
    end
endmodule

/* tb/dpd_ctrl_tb.sv */
// Self-checking bench for the display PLL divisor control
`timescale 1ns/10ps
module dpd_ctrl_tb;
    import dpd_pkg::*;
    logic CLK = 1'b0;
    logic RST = 1'b1;
    logic REG_WR = 1'b0;
    logic REG_RD = 1'b0;
    logic [15:0] REG_ADDR = 16'h0;
    logic [31:0] REG_WDATA = 32'h0;
    logic [3:0] REG_BE = 4'h0;
    wire logic [31:0] REG_RDATA;
    wire logic REG_RVALID;
    wire logic [9:0] pll_n;
    wire logic [9:0] pll_m;
    wire logic [2:0] pll_p;
    wire logic pll_l;
    wire dpd_vco_s pll;
    wire logic [1:0] act;
    wire logic bad_cfg;
    int miscompares = 0;
    int n_checks = 0;
    // Clock
    always #12.5 CLK = ~CLK;
    dpd_ctrl dpd_ctrl_i(.CLK(CLK), .RST(RST), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA), .REG_BE(REG_BE), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
        .PLL_N_DIV(pll_n), .PLL_M_DIV(pll_m), .PLL_POST_DIV(pll_p),
        .PLL_LOOP_DIV16(pll_l), .PLL_ACTIVE_SET(act));
    // Synthesizer sees the divisor outputs as one entry
    assign pll = {pll_n, pll_m, pll_p, pll_l};
    dpd_synth_model dpd_synth_model_i(.clk(CLK), .rst(RST), .cfg(pll), .bad_cfg(bad_cfg));
    // ******
    // Tasks
    // ******
    function automatic logic [31:0] cfg(input logic [9:0] n, input logic [9:0] m, input logic [2:0] p, input logic l);
        return {8'h0, n, m, p, l};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One-cycle write strobe; an idle cycle follows so strobes never merge
    task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] be);
        @(negedge CLK);
        REG_WR = 1'b1;
        REG_ADDR = a;
        REG_WDATA = d;
        REG_BE = be;
        @(negedge CLK);
        REG_WR = 1'b0;
    endtask
    // Answer stands one cycle, so it is sampled at the next falling edge
    task automatic rd(input logic [15:0] a, input logic [31:0] exp);
        @(negedge CLK);
        REG_RD = 1'b1;
        REG_ADDR = a;
        @(negedge CLK);
        REG_RD = 1'b0;
        chk({31'h0, REG_RVALID}, 32'h1);
        chk(REG_RDATA, exp);
    endtask
    task automatic pll_is(input logic [31:0] exp, input logic [1:0] set);
        @(negedge CLK);
        chk({8'h0, pll}, exp);
        chk({30'h0, act}, {30'h0, set});
    endtask
    task automatic test_done();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Watchdog far beyond the fewer than a hundred cycles the run needs
    initial begin
        #100us;
        miscompares++;
        test_done();
    end
    // ******
    // Sequence
    // ******
    initial begin
        repeat (16) @(negedge CLK);
        RST = 1'b0;
        rd(DPD_SET0_DIV_OFS, 32'h00030013);
        rd(DPD_SET1_DIV_OFS, 32'h00100053);
        rd(DPD_SET2_DIV_OFS, 32'h00030013);
        rd(DPD_PANEL_DIV_OFS, 32'h00030013);
        pll_is(cfg(10'h3, 10'h13, 3'h4, 1'b0), 2'h0);
        $display("test reset values done");
        // Staged divisor with reserved bits set, then its byte, then the select
        wr(DPD_SET2_DIV_OFS, 32'hfc2a5555, 4'hf);
        rd(DPD_SET2_DIV_OFS, 32'h002a0155);
        pll_is(cfg(10'h3, 10'h13, 3'h4, 1'b0), 2'h0);
        wr(DPD_POST_SEL_OFS, 32'hff34ffff, 4'h4);
        pll_is(cfg(10'h3, 10'h13, 3'h4, 1'b0), 2'h0);
        wr(DPD_SRC_SEL_OFS, 32'h8, 4'h1);
        pll_is(cfg(10'h2a, 10'h155, 3'h3, 1'b1), 2'h2);
        wr(DPD_SRC_SEL_OFS, 32'h4, 4'h1);
        pll_is(cfg(10'h10, 10'h53, 3'h4, 1'b0), 2'h1);
        wr(DPD_SRC_SEL_OFS, 32'hc, 4'h1);
        pll_is(cfg(10'h2a, 10'h155, 3'h3, 1'b1), 2'h2);
        rd(DPD_SRC_SEL_OFS, 32'hc);
        $display("test staging and select done");
        // Select write alone must carry a freshly staged divisor
        wr(DPD_SET0_DIV_OFS, 32'h00050021, 4'hf);
        wr(DPD_SRC_SEL_OFS, 32'h0, 4'h1);
        pll_is(cfg(10'h5, 10'h21, 3'h4, 1'b0), 2'h0);
        $display("test select transfer done");
        // Panel override wins over the source select until cleared
        wr(DPD_PANEL_DIV_OFS, 32'h00070011, 4'hf);
        wr(DPD_POST_SEL_OFS, 32'h50000000, 4'h8);
        wr(DPD_PANEL_CTL_OFS, 32'h80000001, 4'hf);
        pll_is(cfg(10'h7, 10'h11, 3'h5, 1'b0), 2'h3);
        wr(DPD_SRC_SEL_OFS, 32'h4, 4'h1);
        pll_is(cfg(10'h7, 10'h11, 3'h5, 1'b0), 2'h3);
        wr(DPD_PANEL_CTL_OFS, 32'h80000000, 4'hf);
        pll_is(cfg(10'h10, 10'h53, 3'h4, 1'b0), 2'h1);
        rd(DPD_PANEL_CTL_OFS, 32'h80000000);
        $display("test panel override done");
        // A post byte write on the running set reaches the synthesizer at once
        wr(DPD_POST_SEL_OFS, 32'h00001400, 4'h2);
        pll_is(cfg(10'h10, 10'h53, 3'h1, 1'b1), 2'h1);
        rd(DPD_POST_SEL_OFS, 32'h50341440);
        $display("test post on active set done");
        wr(16'h601c, 32'hffffffff, 4'hf);
        rd(16'h601c, 32'h0);
        chk({31'h0, bad_cfg}, 32'h0);
        $display("test unmapped done");
        // Reset in mid-run must bring back the set 0 divisor, post select, source select and PLL reset values
        @(negedge CLK);
        RST = 1'b1;
        repeat (4) @(negedge CLK);
        RST = 1'b0;
        rd(DPD_SET0_DIV_OFS, 32'h00030013);
        rd(DPD_POST_SEL_OFS, 32'h40404040);
        rd(DPD_SRC_SEL_OFS, 32'h0);
        pll_is(cfg(10'h3, 10'h13, 3'h4, 1'b0), 2'h0);
        $display("test mid-run reset done");
        test_done();
    end
endmodule
